// ### core/conv_port_pkg.sv
// shared constants and carrier types for the conversion and read port
package conv_port_pkg;

    localparam int RESULT_W         = 14;
    localparam int CONV_CYCLES      = 16;
    localparam int CLK_FREQ_HZ      = 20_000_000;
    // internal oscillator half period as a count of ref_clk cycles
    localparam int INT_OSC_HALF     = 2;
    localparam int FIFO_DEPTH       = 8;
    localparam logic [13:0] RESULT_RESET = 14'h0000;
    // bipolar variants use two's complement, unipolar straight binary
    localparam bit BIPOLAR_DEFAULT  = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_CLK,
        ST_CONVERT
    } conv_state_e;

    // one finished conversion as it travels towards the output latch
    typedef struct packed {
        logic        ext_clk;
        logic [13:0] code;
    } sample_s;

endpackage

// ### core/sample_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sample_fifo
    import conv_port_pkg::*;
#(
    parameter int WIDTH = 15,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // clock and reset
    input  wire  logic             ref_clk,
    input  wire  logic             rst,
    // write side
    input  wire  logic [WIDTH-1:0] in_data,
    input  wire  logic             in_valid,
    output logic                   in_ready,
    // read side
    output logic [WIDTH-1:0]       out_data,
    output logic                   out_valid,
    input  wire  logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic [WIDTH-1:0] dout_r;
    logic [WIDTH-1:0] dout_nxt;
    logic             wr;
    logic             rd;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = dout_r;
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    // pointer and count update; read data is registered head of queue
    always_comb
    begin
        wp_nxt   = wr ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt   = rd ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt  = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
        dout_nxt = (cnt_nxt == '0) ? dout_r
                 : ((cnt_r == '0 || (rd && cnt_r == 1)) && wr) ? in_data
                 : mem_r[rp_nxt];
    end

    always_ff @(posedge ref_clk)
    begin
        if (wr)
        begin
            mem_r[wp_r] <= in_data;
        end
        if (rst)
        begin
            wp_r   <= '0;
            rp_r   <= '0;
            cnt_r  <= '0;
            dout_r <= '0;
        end
        else
        begin
            wp_r   <= wp_nxt;
            rp_r   <= rp_nxt;
            cnt_r  <= cnt_nxt;
            dout_r <= dout_nxt;
        end
    end
endmodule
`default_nettype wire

// ### core/sar_conv_port.sv
// conversion control, status output and three-state result port
`timescale 1ns/1ns
`default_nettype none
module sar_conv_port
    import conv_port_pkg::*;
#(
    parameter int  WIDTH   = RESULT_W,
    parameter bit  BIPOLAR = BIPOLAR_DEFAULT
)
(
    // clock and reset
    input  wire  logic             ref_clk,
    input  wire  logic             rst,
    // conversion control pins
    input  wire  logic             sample_trigger,
    input  wire  logic             conversion_clock_in,
    input  wire  logic             power_save_n,
    // read strobes
    input  wire  logic             select_n,
    input  wire  logic             read_n,
    // comparator decision from the analog core, one per bit trial
    input  wire  logic             cmp_in,
    // status and result bus
    output logic                   busy,
    output logic                   track_hold,
    output logic [WIDTH-1:0]       result_bus_o,
    output logic [WIDTH-1:0]       result_bus_oe,
    output logic                   standby
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage is read only by the second
    logic [4:0] s1_r;
    logic [4:0] s2_r;
    logic       trig_d_r;
    logic       cin_d_r;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // idle pin levels, so no false read or edge follows reset
            s1_r     <= 5'h0c;
            s2_r     <= 5'h0c;
            trig_d_r <= 1'b0;
            cin_d_r  <= 1'b0;
        end
        else
        begin
            s1_r     <= {cmp_in, read_n, select_n, conversion_clock_in, sample_trigger};
            s2_r     <= s1_r;
            trig_d_r <= s2_r[0];
            cin_d_r  <= s2_r[1];
        end
    end

    logic trig_s;
    logic cin_s;
    logic sel_s;
    logic rd_s;
    logic cmp_s;
    logic pwr_on;
    logic pwr_s1_r;
    logic pwr_s2_r;
    logic trig_rise;
    logic cin_rise;
    logic start;

    assign trig_s    = s2_r[0];
    assign cin_s     = s2_r[1];
    assign sel_s     = ~s2_r[2];
    assign rd_s      = ~s2_r[3];
    assign cmp_s     = s2_r[4];
    assign pwr_on    = pwr_s2_r;
    assign trig_rise = trig_s && !trig_d_r;
    assign cin_rise  = cin_s && !cin_d_r;

    // power-save synchroniser, kept apart so standby is its own level
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // awake level, so standby does not blink out of reset
            pwr_s1_r <= 1'b1;
            pwr_s2_r <= 1'b1;
        end
        else
        begin
            pwr_s1_r <= power_save_n;
            pwr_s2_r <= pwr_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // internal oscillator: enable pulse divider
    // restarted at each start so the first step is a whole period
    logic [3:0] osc_cnt_r;
    logic [3:0] osc_cnt_nxt;
    logic       osc_tick;

    assign osc_tick = (osc_cnt_r == 4'(2*INT_OSC_HALF - 1));

    always_comb
    begin
        osc_cnt_nxt = (start || osc_tick) ? 4'h0 : osc_cnt_r + 4'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            osc_cnt_r <= 4'h0;
        end
        else
        begin
            osc_cnt_r <= osc_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // successive approximation sequencer
    conv_state_e      st_r;
    conv_state_e      st_nxt;
    logic             ext_r;
    logic             ext_nxt;
    logic [4:0]       cyc_r;
    logic [4:0]       cyc_nxt;
    logic [WIDTH-1:0] sar_r;
    logic [WIDTH-1:0] sar_nxt;
    logic             push;
    logic             step;
    sample_s          push_data;

    // one conversion clock cycle, from whichever source was chosen
    assign step = ext_r ? cin_rise : osc_tick;

    // a trigger edge counts only when idle and powered; others are dropped
    assign start = (st_r == ST_IDLE) && trig_rise && pwr_on;

    // bit position under trial for a given cycle count
    function automatic logic [WIDTH-1:0] trial_bit(input logic [4:0] c);
        trial_bit = (c < 5'(WIDTH)) ? (WIDTH)'(1) << (WIDTH - 1 - int'(c)) : '0;
    endfunction

    always_comb
    begin
        st_nxt  = st_r;
        ext_nxt = ext_r;
        cyc_nxt = cyc_r;
        sar_nxt = sar_r;
        push    = 1'b0;
        unique case (st_r)
            ST_IDLE:
            begin
                if (start)
                begin
                    ext_nxt = cin_s;
                    cyc_nxt = 5'h00;
                    sar_nxt = trial_bit(5'h00);
                    st_nxt  = ST_CONVERT;
                end
            end
            ST_WAIT_CLK:
            begin
                st_nxt = ST_CONVERT;
            end
            ST_CONVERT:
            begin
                if (step)
                begin
                    if (cyc_r < 5'(WIDTH))
                    begin
                        // keep or drop the trial bit, then set the next one
                        if (!cmp_s)
                        begin
                            sar_nxt = sar_r & ~trial_bit(cyc_r);
                        end
                        sar_nxt = sar_nxt | trial_bit(cyc_r + 5'h01);
                    end
                    cyc_nxt = cyc_r + 5'h01;
                    if (cyc_r == 5'(CONV_CYCLES - 1))
                    begin
                        push   = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r  <= ST_IDLE;
            ext_r <= 1'b0;
            cyc_r <= 5'h00;
            sar_r <= '0;
        end
        else
        begin
            st_r  <= st_nxt;
            ext_r <= ext_nxt;
            cyc_r <= cyc_nxt;
            sar_r <= sar_nxt;
        end
    end

    // bipolar parts flip the msb to turn offset binary into two's complement
    assign push_data.ext_clk = ext_r;
    assign push_data.code    = BIPOLAR ? {~sar_r[WIDTH-1], sar_r[WIDTH-2:0]} : sar_r;

    ////////////////////////////////////////////////////////////////////
    // results queue: drained into the output latch when the bus is idle
    sample_s pop_data;
    logic    pop_valid;
    logic    pop_ready;
    logic    fifo_in_ready;
    logic    reading;

    assign reading   = sel_s && rd_s;
    // latch is not swapped mid read so a read never sees a torn word
    assign pop_ready = !reading;

    sample_fifo #(
        .WIDTH ($bits(sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_data   (push_data),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (pop_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // output registers: status, track/hold, latch and bus drive
    logic             busy_r;
    logic             busy_nxt;
    logic [WIDTH-1:0] latch_r;
    logic [WIDTH-1:0] latch_nxt;
    logic             oe_r;
    logic             oe_nxt;
    logic             power_save_n_r;
    logic             power_save_n_nxt;
    logic             th_r;
    logic             th_nxt;

    always_comb
    begin
        // busy covers the conversion and any result still queued;
        // push bridges the cycle before the queue shows the new word,
        // so busy never dips between conversion end and latch load
        // a full queue also holds busy so the host sees back-pressure
        busy_nxt  = (st_nxt != ST_IDLE) || push || pop_valid || !fifo_in_ready;
        th_nxt    = (st_nxt != ST_IDLE);
        latch_nxt = (pop_valid && pop_ready) ? pop_data.code : latch_r;
        oe_nxt    = reading;
        power_save_n_nxt  = !pwr_on && (st_nxt == ST_IDLE);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            busy_r  <= 1'b0;
            latch_r <= RESULT_RESET;
            oe_r    <= 1'b0;
            power_save_n_r  <= 1'b0;
            th_r    <= 1'b0;
        end
        else
        begin
            busy_r  <= busy_nxt;
            latch_r <= latch_nxt;
            oe_r    <= oe_nxt;
            power_save_n_r  <= power_save_n_nxt;
            th_r    <= th_nxt;
        end
    end

    assign busy          = busy_r;
    assign track_hold    = th_r;                       // high while holding
    assign result_bus_o  = latch_r;
    assign result_bus_oe = {WIDTH{oe_r}};
    assign standby       = power_save_n_r;
endmodule
`default_nettype wire

// ### verif/sar_conv_port_checker.sv
// pin level assertions for the conversion and read port
`timescale 1ns/1ns
`default_nettype none
module sar_conv_port_checker
    import conv_port_pkg::*;
#(
    parameter int WIDTH = RESULT_W
)
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // pins seen at the port
    input  wire logic             sample_trigger,
    input  wire logic             conversion_clock_in,
    input  wire logic             power_save_n,
    input  wire logic             select_n,
    input  wire logic             read_n,
    input  wire logic             busy,
    input  wire logic             track_hold,
    input  wire logic [WIDTH-1:0] result_bus_o,
    input  wire logic [WIDTH-1:0] result_bus_oe,
    input  wire logic             standby
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] len_r;
    logic [7:0] len_nxt;
    logic [4:0] rise_r;
    logic [4:0] rise_nxt;
    logic       clk_d_r;
    // busy length and clock pin rises, restarted with each conversion
    always_comb
    begin
        len_nxt  = busy ? len_r + 8'h01 : 8'h00;
        rise_nxt = busy ? rise_r + 5'(conversion_clock_in && !clk_d_r) : 5'h00;
    end
    // registers only
    always_ff @(posedge ref_clk)
    begin
        len_r   <= rst ? 8'h00 : len_nxt;
        rise_r  <= rst ? 5'h00 : rise_nxt;
        clk_d_r <= conversion_clock_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence strobes_on;
        (!select_n && !read_n) [*5];
    endsequence
    sequence strobes_off;
        (select_n || read_n) [*5];
    endsequence
    AST_OE_ON: assert property (strobes_on |-> result_bus_oe == '1)
        else $error("bus not driven during read");
    AST_OE_OFF: assert property (strobes_off |-> result_bus_oe == '0)
        else $error("bus driven without read and select");
    AST_BUS_WHOLE: assert property (result_bus_oe == '0 || result_bus_oe == '1)
        else $error("bus lines enabled apart");
    AST_START: assert property ($rose(sample_trigger) && !busy && !standby && power_save_n
        && $past(power_save_n, 4) |-> ##[3:5] busy)
        else $error("trigger did not start a conversion");
    AST_HOLD_START: assert property ($rose(busy) |-> track_hold [*8])
        else $error("input not held at conversion start");
    AST_HOLD_IN_CONV: assert property (track_hold |-> busy)
        else $error("hold outside conversion");
    AST_INT_TIME: assert property ($fell(busy) && rise_r == 5'h00
        |-> len_r >= 8'h40 && len_r <= 8'h48)
        else $error("internal conversion length wrong");
    AST_EXT_COUNT: assert property ($fell(busy) && rise_r != 5'h00 |-> rise_r == 5'h10)
        else $error("external conversion not sixteen clocks");
    AST_STANDBY: assert property ((!power_save_n && !busy) [*6] |-> standby)
        else $error("standby not entered");
    AST_NO_START_SLEEP: assert property ((!power_save_n) [*8] |-> !$rose(busy))
        else $error("conversion started in standby");
    AST_LATCH_KEEP: assert property (!busy && !$past(busy) && !$past(busy, 2)
        |-> $stable(result_bus_o))
        else $error("latch changed while idle");
endmodule
bind sar_conv_port sar_conv_port_checker #(.WIDTH(WIDTH)) chk (.ref_clk, .rst,
    .sample_trigger, .conversion_clock_in, .power_save_n, .select_n, .read_n, .busy,
    .track_hold, .result_bus_o, .result_bus_oe, .standby);
`default_nettype wire

// ### verif/host_model.sv
// host side model: trigger, external clock and read strobes
`timescale 1ns/1ns
`default_nettype none
module host_model
    import conv_port_pkg::*;
(
    // clock
    input  wire logic                ref_clk,
    // device pins
    output logic                     sample_trigger,
    output logic                     conversion_clock_in,
    output logic                     select_n,
    output logic                     read_n,
    input  wire logic [RESULT_W-1:0] result_bus_o,
    input  wire logic [RESULT_W-1:0] result_bus_oe
);
    // idle pins; clock pin low keeps the internal oscillator
    initial
    begin
        sample_trigger      = 1'b0;
        conversion_clock_in = 1'b0;
        select_n            = 1'b1;
        read_n              = 1'b1;
    end
    // trigger pulse, then sixteen clock periods if external
    task automatic convert(input bit ext, input int half);
        @(posedge ref_clk) #2;
        conversion_clock_in = ext;
        sample_trigger = 1'b1;
        repeat (6) @(posedge ref_clk);
        #2 sample_trigger = 1'b0;
        conversion_clock_in = 1'b0;
        // clock stands still between conversions, starts well late
        repeat (ext ? 32 : 0)
        begin
            repeat (half) @(posedge ref_clk);
            #2 conversion_clock_in = !conversion_clock_in;
        end
    endtask
    task automatic strobe(input bit s, input bit r);
        @(posedge ref_clk) #2;
        select_n = s;
        read_n = r;
    endtask
    // read with both strobes, bounded wait for the bus
    task automatic read_word(output logic [RESULT_W-1:0] d, output bit ok);
        ok = 1'b0;
        d = '0;
        strobe(1'b0, 1'b0);
        for (int i = 0; i < 10 && !ok; i++)
        begin
            // look just after the edge, once the outputs have settled
            @(posedge ref_clk) #2;
            ok = (result_bus_oe === '1);
            d = result_bus_o;
        end
        strobe(1'b1, 1'b1);
        // the bus enable lags the strobes; let it fall before the next read
        repeat (4) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ### verif/sar_adc_conversion_and_read_port_tb.sv
// self-checking bench for the conversion and read port
`timescale 1ns/1ns
`default_nettype none
module sar_adc_conversion_and_read_port_tb;
    import conv_port_pkg::*;
    logic                ref_clk;
    logic                rst;
    logic                power_save_n;
    logic                cmp_in;
    logic                sample_trigger;
    logic                conversion_clock_in;
    logic                select_n;
    logic                read_n;
    logic                busy;
    logic                track_hold;
    logic                standby;
    logic [RESULT_W-1:0] result_bus_o;
    logic [RESULT_W-1:0] result_bus_oe;
    logic [RESULT_W-1:0] got;
    logic [RESULT_W-1:0] exp_q[$];
    bit                  ok;
    int                  failures;
    int                  check_count;
    // track/hold settling before the next trigger: 0.3 us at 50 ns
    localparam int       ACQ_CYCLES = 6;
    sar_conv_port uut (.ref_clk, .rst, .sample_trigger, .conversion_clock_in, .power_save_n,
        .select_n, .read_n, .cmp_in, .busy, .track_hold, .result_bus_o, .result_bus_oe,
        .standby);
    host_model host (.ref_clk, .sample_trigger, .conversion_clock_in, .select_n, .read_n,
        .result_bus_o, .result_bus_oe);
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = !ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] want);
        check_count++;
        if (seen !== want)
        begin
            failures++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    // comparator held constant keeps or drops every trial; msb flipped as bipolar
    function automatic logic [RESULT_W-1:0] model(input bit c);
        int v;
        v = (c ? 16383 : 0) ^ 8192;
        return v[RESULT_W-1:0];
    endfunction
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            tick(1);
            n++;
        end
        if (n == 400)
        begin
            failures++;
            end_sim();
        end
        tick(ACQ_CYCLES);
    endtask
    task automatic run(input bit e, input bit c);
        cmp_in = c;
        host.convert(e, 2 + $urandom % 3);
        wait_idle();
        exp_q.push_back(model(c));
        check({13'h0000, track_hold}, 14'h0000);
    endtask
    task automatic rd(input logic [RESULT_W-1:0] want);
        host.read_word(got, ok);
        check({13'h0000, ok}, 14'h0001);
        check(got, want);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        failures = 0;
        check_count = 0;
        rst = 1'b1;
        power_save_n = 1'b1;
        cmp_in = 1'b0;
        void'($urandom(88976));
        tick(10);
        rst = 1'b0;
        tick(1);
        // pins seen at their idle levels from the first edge out of reset
        check({13'h0000, standby}, 14'h0000);
        check(result_bus_oe, 14'h0000);
        check({13'h0000, busy}, 14'h0000);
        tick(4);
        check(result_bus_o, RESULT_RESET);
        check(result_bus_oe, 14'h0000);
        // first four cover both clocks and both comparator levels
        for (int i = 0; i < 8; i++)
        begin
            run(i < 4 ? i[0] : 1'($urandom), i < 4 ? i[1] : 1'($urandom));
            rd(exp_q[0]);
            rd(exp_q.pop_front());
        end
        $display("conversions done");
        for (int k = 0; k < 2; k++)
        begin
            host.strobe(k[0], !k[0]);
            tick(8);
            check(result_bus_oe, 14'h0000);
        end
        host.strobe(1'b1, 1'b1);
        $display("partial strobes done");
        // a second trigger mid conversion must be dropped silently
        cmp_in = 1'b1;
        host.convert(1'b0, 2);
        tick(14);
        host.convert(1'b0, 2);
        wait_idle();
        tick(10);
        check({13'h0000, busy}, 14'h0000);
        rd(model(1'b1));
        $display("retrigger done");
        power_save_n = 1'b0;
        tick(8);
        check({13'h0000, standby}, 14'h0001);
        host.convert(1'b0, 2);
        tick(8);
        check({13'h0000, busy}, 14'h0000);
        power_save_n = 1'b1;
        tick(8);
        check({13'h0000, standby}, 14'h0000);
        $display("standby done");
        // a read held over the end keeps the old word until released
        cmp_in = 1'b0;
        host.strobe(1'b0, 1'b0);
        host.convert(1'b1, 3);
        tick(10);
        check({13'h0000, busy}, 14'h0001);
        check(result_bus_o, model(1'b1));
        host.strobe(1'b1, 1'b1);
        wait_idle();
        rd(model(1'b0));
        $display("held read done");
        end_sim();
    end
endmodule
`default_nettype wire
